// File: common/hbh_pkg.sv
package hbh_pkg;
  // bus ownership states
  typedef enum logic [3:0] {
    HBH_OWN  = 4'h1,
    HBH_DRAIN = 4'h2,
    HBH_GRANT = 4'h4,
    HBH_IDLE = 4'h8
  } hbh_state_t;
  localparam int HBH_PEER_LINES = 6;
  localparam int HBH_DRAIN_CYCLES = 1;
  localparam logic HBH_GRANT_RESET_N = 1'b1;
  localparam logic HBH_ACK_RESET = 1'b1;
endpackage

// File: verilog/hbh_port.sv
// How it works
// - once the bus is given up, address, data, select and strobe enables go low.
// - a pending host request wins over every peer processor bus request.
// - the low grant stays low, unbroken, until the host withdraws its request.
// - only the current bus master drives the grant line; others just watch it.
// - with chip select and host request both active, acknowledge is held low for waits.
`timescale 1ns/1ps
module hbh_port #(
  parameter int PEER_LINES = hbh_pkg::HBH_PEER_LINES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic host_bus_request_n,
  input wire logic chip_select_n,
  input wire logic is_bus_master,
  input wire logic [PEER_LINES-1:0] peer_bus_request_lines_n,
  input wire logic io_access_done,
  output logic host_bus_grant_n_o,
  output logic host_bus_grant_n_oe,
  output logic host_access_acknowledge_o,
  output logic host_access_acknowledge_oe,
  output logic ext_bus_oe,
  output logic peer_grant
);
  import hbh_pkg::*;

  localparam int SYNC_PINS = 2;
  localparam int DRAIN_W = (HBH_DRAIN_CYCLES > 1) ? $clog2(HBH_DRAIN_CYCLES) : 1;

  // elaboration checks
  if (PEER_LINES < 1 || PEER_LINES > HBH_PEER_LINES) begin : g_bad_peer
    $error("PEER_LINES must be 1 to 6");
  end
  if (HBH_DRAIN_CYCLES < 1) begin : g_bad_drain
    $error("drain needs at least one cycle");
  end

  // state decodes
  function automatic logic holds_grant(input hbh_state_t st);
    return st == HBH_GRANT;
  endfunction

  function automatic logic owns_bus(input hbh_state_t st);
    return st == HBH_OWN;
  endfunction

  logic [SYNC_PINS-1:0] async_in;
  logic [SYNC_PINS-1:0] synced;
  logic host_req;
  logic host_sel;
  hbh_state_t state_reg, state_next;
  logic [DRAIN_W-1:0] drain_cnt_reg, drain_cnt_next;
  logic drain_done;
  logic grant_n_reg, grant_n_next;
  logic grant_oe_reg, grant_oe_next;
  logic bus_oe_reg, bus_oe_next;
  logic peer_reg, peer_next;
  logic ack_oe_reg, ack_oe_next;

  // host input synchronisers
  assign async_in = {~chip_select_n, ~host_bus_request_n};

  for (genvar gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
    logic meta_reg, meta_next;
    logic stable_reg, stable_next;

    always_comb begin
      meta_next = async_in[gi];
      stable_next = meta_reg;
    end

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        meta_reg <= 1'b0;
        stable_reg <= 1'b0;
      end else begin
        meta_reg <= meta_next;
        stable_reg <= stable_next;
      end
    end

    assign synced[gi] = stable_reg;
  end

  assign host_req = synced[0];
  assign host_sel = synced[1];

  // bus ownership state
  assign drain_done = drain_cnt_reg == DRAIN_W'(HBH_DRAIN_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    drain_cnt_next = '0;
    case (state_reg)
      HBH_OWN: begin
        if (host_req && is_bus_master) begin
          state_next = HBH_DRAIN;
        end else if (host_req) begin
          state_next = HBH_IDLE;
        end
      end
      HBH_DRAIN: begin
        if (drain_done) begin
          state_next = HBH_GRANT;
        end else begin
          drain_cnt_next = drain_cnt_reg + 1'b1;
        end
      end
      HBH_GRANT: begin
        if (!host_req) begin
          state_next = HBH_OWN;
        end
      end
      HBH_IDLE: begin
        if (!host_req) begin
          state_next = HBH_OWN;
        end
      end
      default: begin
        state_next = HBH_OWN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= HBH_OWN;
      drain_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      drain_cnt_reg <= drain_cnt_next;
    end
  end

  // grant line
  always_comb begin
    grant_n_next = !holds_grant(state_next);
    grant_oe_next = is_bus_master && (state_next != HBH_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      grant_n_reg <= HBH_GRANT_RESET_N;
      grant_oe_reg <= 1'b0;
    end else begin
      grant_n_reg <= grant_n_next;
      grant_oe_reg <= grant_oe_next;
    end
  end

  // external bus drive
  always_comb begin
    bus_oe_next = is_bus_master && owns_bus(state_next);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_oe_reg <= 1'b0;
    end else begin
      bus_oe_reg <= bus_oe_next;
    end
  end

  // peer arbitration
  always_comb begin
    peer_next = !host_req && !holds_grant(state_next) && !(&peer_bus_request_lines_n);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      peer_reg <= 1'b0;
    end else begin
      peer_reg <= peer_next;
    end
  end

  // acknowledge wait states
  always_comb begin
    ack_oe_next = host_req && host_sel && !io_access_done;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_oe_reg <= !HBH_ACK_RESET;
    end else begin
      ack_oe_reg <= ack_oe_next;
    end
  end

  assign host_bus_grant_n_o = grant_n_reg;
  assign host_bus_grant_n_oe = grant_oe_reg;
  assign host_access_acknowledge_o = 1'b0;
  assign host_access_acknowledge_oe = ack_oe_reg;
  assign ext_bus_oe = bus_oe_reg;
  assign peer_grant = peer_reg;

  // checks
  a_bus_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !grant_n_reg |-> !bus_oe_reg) else $error("bus driven while granted");
  a_grant_drain: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == HBH_DRAIN) |=> !grant_n_reg) else $error("grant not after drain");
  a_grant_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!grant_n_reg && host_req) |=> !grant_n_reg) else $error("grant dropped early");
  a_host_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_req |=> !peer_reg) else $error("peer won over host");
  a_ack_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (host_req && host_sel && !io_access_done) |=> ack_oe_reg) else $error("no wait");
  a_ack_free: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !host_req |=> !ack_oe_reg) else $error("wait without request");
  a_grant_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !is_bus_master |=> !grant_oe_reg) else $error("non-master drove grant");
  a_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!grant_n_reg && !host_req) |=> grant_n_reg ##1 1'b1) else $error("no release");
  a_sync_lag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(g_sync[0].meta_reg) |=> host_req) else $error("sync lag wrong");
  a_drain_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == HBH_DRAIN) |-> !bus_oe_reg) else $error("bus driven in drain");
  a_peer_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !grant_n_reg |-> !peer_reg) else $error("peer served while granted");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == HBH_IDLE) |-> !grant_oe_reg && !bus_oe_reg) else $error("idle drove");

  c_grant: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(grant_n_reg));
  c_wait: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(ack_oe_reg));
  c_resume: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(bus_oe_reg));
  c_idle: cover property (@(posedge ref_clk) disable iff (sys_rst) state_reg == HBH_IDLE);
  c_done: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(ack_oe_reg));
endmodule

// File: testbench/hbh_host_model.sv
`timescale 1ns/1ps
module hbh_host_model (
  input wire logic ref_clk,
  input wire logic want,
  input wire logic grant_n,
  output logic req_n,
  output logic cs_n
);
  initial begin
    req_n = 1'b1;
    cs_n = 1'b1;
  end
  always @(posedge ref_clk) begin
    req_n <= !want;
    cs_n <= !(want && !grant_n);
  end
endmodule

// File: testbench/hbh_port_tb_top.sv
`timescale 1ns/1ps
module hbh_port_tb_top;
  import hbh_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, want = 1'b0, mst = 1'b1, done = 1'b0;
  logic [HBH_PEER_LINES-1:0] peer_n = '1;
  logic req_n, cs_n, g_o, g_oe, a_o, a_oe, bus_oe, pg;
  wire logic grant_n = g_oe ? g_o : 1'b1;
  int bad_count = 0, check_count = 0, n;
  int lat_q[$] = '{3 + HBH_DRAIN_CYCLES + 1, 4};
  hbh_port dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_bus_request_n(req_n),
    .chip_select_n(cs_n), .is_bus_master(mst), .peer_bus_request_lines_n(peer_n),
    .io_access_done(done), .host_bus_grant_n_o(g_o), .host_bus_grant_n_oe(g_oe),
    .host_access_acknowledge_o(a_o), .host_access_acknowledge_oe(a_oe),
    .ext_bus_oe(bus_oe), .peer_grant(pg));
  hbh_host_model host_u (.ref_clk(ref_clk), .want(want), .grant_n(grant_n),
    .req_n(req_n), .cs_n(cs_n));
  initial forever #12.5 ref_clk = !ref_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim;
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'ha431d007));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      @(posedge ref_clk);
      mst <= (r == 0);
      peer_n <= $urandom;
      want <= 1'b1;
      n = 0;
      do begin step(); n++; end while (grant_n !== 1'b0 && n < 12);
      if (r == 1) chk(g_oe, 1'b0, "idle grant oe");
      if (r == 1) continue;
      chk(n, lat_q[0], "grant latency");
      chk(bus_oe, 1'b0, "bus oe");
      chk(pg, 1'b0, "peer grant");
      repeat (8 + $urandom_range(3)) begin
        step();
        chk(grant_n, 1'b0, "grant held");
      end
      chk({a_oe, a_o}, 2'h2, "ack wait");
      @(posedge ref_clk);
      done <= 1'b1;
      step();
      chk(a_oe, 1'b0, "ack done");
      @(posedge ref_clk);
      want <= 1'b0;
      done <= 1'b0;
      n = 0;
      do begin step(); n++; end while (grant_n !== 1'b1 && n < 12);
      chk(n, lat_q[1], "release latency");
      chk(bus_oe, 1'b1, "bus resume");
    end
    want <= 1'b0;
    step();
    end_sim();
  end
endmodule
